/* File: design/darc_ctrl.sv */
// Purpose: DRAM access and refresh controller with two request ports and AHB-Lite setup.
// Assumes: Pin inputs are asynchronous to hclk; AHB-Lite signals are synchronous to it.
// Notes: All pin inputs pass two flip-flops, so pin to strobe latency is at least 3 edges.
`timescale 1ns/1ps
`default_nettype none

module darc_ctrl
  import darc_pkg::*;
#(
  parameter int WARMUP_CYCLES = WARMUP_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [10:0] row_addr_in,
  input wire logic [10:0] col_addr_in,
  input wire logic [1:0] bank_select_in,
  input wire logic [3:0] cas_enable_in_n,
  input wire logic column_step_in,
  input wire logic port_a_request,
  input wire logic port_b_request,
  input wire logic write_in,
  input wire logic wait_extend_in,
  input wire logic program_load_n,
  input wire logic refresh_disable_in_n,
  input wire logic refresh_request_in,
  output logic [10:0] dram_addr,
  output logic [3:0] ras_out_n,
  output logic [3:0] cas_out_n,
  output logic we_out_n,
  output logic wait_out,
  output logic port_b_owner,
  output logic port_b_early_ack,
  output logic refresh_active_n,
  output logic refresh_due
);

  if (WARMUP_CYCLES < 1 || WARMUP_CYCLES > 4194303 || RAS_MIN_CYC > 15) begin : g_bad_param
    $error("darc_ctrl: warm-up or RAS timing does not fit its counter");
  end

  darc_state_t s;
  darc_state_t n;
  darc_pins_t p;
  darc_status_t stat;
  logic [3:0] busy;
  logic [3:0] rmask;
  logic [3:0] bmask;
  logic [3:0] casgrp;
  logic [1:0] rtype;
  logic [10:0] row_v;
  logic [10:0] col_v;
  logic tick;
  logic load_ml;
  logic load_bus;
  logic warm_on;
  logic req_own;
  logic req_oth;
  logic acc;
  logic refr;
  logic waitact;
  logic scrub;
  logic addr_phase;

  function automatic logic [3:0] bank_mask(input logic [1:0] sel, input logic [1:0] b);
    logic [3:0] m;
    m = 4'hF;
    if (sel == BANKS_TWO)
    begin
      m = b[0] ? 4'hC : 4'h3;
    end
    else if (sel == BANKS_FOUR)
    begin
      m = 4'h1 << b;
    end
    return m;
  endfunction

  always_comb
  begin
    n = s;
    p = s.sync2;
    n.sync1 = {row_addr_in, col_addr_in, bank_select_in, cas_enable_in_n, column_step_in,
               port_a_request, port_b_request, write_in, wait_extend_in, program_load_n,
               refresh_disable_in_n, refresh_request_in};
    n.sync2 = s.sync1;
    for (int i = 0; i < 4; i++)
    begin
      busy[i] = s.pre[i] != 3'h0;
      if (busy[i])
      begin
        n.pre[i] = s.pre[i] - 3'h1;
      end
    end

    // Bus slave: zero wait states, read data prepared during the address phase.
    stat = '0;
    stat.rf_row = s.rf_row;
    stat.fsm = s.st;
    stat.owner_b = s.owner_b;
    stat.rf_pend = s.rf_pend;
    stat.warm = s.warm != 22'h0;
    stat.prog_done = s.prog_done;
    addr_phase = hsel && hready && htrans[1];
    n.h_wr = addr_phase && hwrite && hsize == HSIZE_WORD;
    n.h_addr = addr_phase ? haddr[7:0] : s.h_addr;
    n.hrdata = 32'h0;
    if (addr_phase && !hwrite && haddr[7:0] == REG_CONFIG)
    begin
      n.hrdata = {21'h0, s.cfg};
    end
    else if (addr_phase && !hwrite && haddr[7:0] == REG_STATUS)
    begin
      n.hrdata = stat;
    end
    n.hready = 1'b1;
    n.h_err = 1'b0;

    // Programming through the address pins or a bus write.
    load_ml = !p.ml_n && p.dis_n;
    load_bus = s.h_wr && s.h_addr == REG_CONFIG;
    warm_on = s.warm != 22'h0;
    if (warm_on)
    begin
      n.warm = s.warm - 22'h1;
    end
    if (load_ml || load_bus)
    begin
      n.cfg = load_ml ? p.col : hwdata[CFG_W-1:0];
      n.prog_done = 1'b1;
      if (!s.prog_done)
      begin
        n.warm = WARMUP_CYCLES[21:0];
      end
    end
    if (!p.ml_n && !p.dis_n)
    begin
      if (s.rst_cnt != EXT_RESET_EDGES)
      begin
        n.rst_cnt = s.rst_cnt + 5'h1;
      end
    end
    else
    begin
      n.rst_cnt = 5'h0;
    end

    // Refresh request timer.
    tick = s.rf_tmr == 10'(REFRESH_CYC - 1);
    n.rf_tmr = tick ? 10'h0 : s.rf_tmr + 10'h1;
    rtype = warm_on ? RT_CONV : s.cfg[CFG_RTYPE_LSB +: 2];
    rmask = (rtype == RT_SPREAD) ? (4'h1 << s.rf_bank) : 4'hF;
    bmask = bank_mask(s.cfg[CFG_BANKS_LSB +: 2], p.bank);
    req_own = s.owner_b ? p.req_b : p.req_a;
    req_oth = s.owner_b ? p.req_a : p.req_b;
    n.cnt = (s.cnt == 4'hF) ? s.cnt : s.cnt + 4'h1;

    unique case (s.st)
      ST_IDLE:
      begin
        n.cnt = 4'h0;
        if (s.rf_pend && (rmask & busy) == 4'h0)
        begin
          n.st = ST_REF;
          n.mask = rmask;
          n.rf_pend = 1'b0;
          n.rf_due = 1'b0;
        end
        else if (s.prog_done && !warm_on && req_own && (bmask & busy) == 4'h0)
        begin
          n.row = p.row;
          n.col = p.col;
          n.mask = bmask;
          n.we = p.wr;
          n.st = s.cfg[CFG_MODE1] ? ST_RAS : ST_ARM;
        end
        else if (!req_own && req_oth)
        begin
          n.owner_b = !s.owner_b;
        end
      end
      ST_ARM:
      begin
        n.cnt = 4'h0;
        n.st = ST_RAS;
      end
      ST_RAS:
      begin
        n.st = ST_CAS;
      end
      ST_CAS:
      begin
        if (p.step && !s.cfg[CFG_TRANSP])
        begin
          n.col = s.col + 11'h1;
        end
        if (!req_own && s.cnt >= 4'(RAS_MIN_CYC - 1))
        begin
          n.st = ST_IDLE;
          for (int i = 0; i < 4; i++)
          begin
            if (s.mask[i])
            begin
              n.pre[i] = 3'(PRECHARGE_CYC);
            end
          end
        end
      end
      ST_REF:
      begin
        // Column step held high stretches the refresh RAS pulse.
        if (s.cnt >= 4'(RAS_MIN_CYC - 1) && !p.step)
        begin
          n.st = ST_IDLE;
          for (int i = 0; i < 4; i++)
          begin
            if (s.mask[i])
            begin
              n.pre[i] = 3'(PRECHARGE_CYC);
            end
          end
          if (rtype == RT_SPREAD)
          begin
            n.rf_bank = s.rf_bank + 2'h1;
          end
          if (rtype != RT_SPREAD || s.rf_bank == 2'h3)
          begin
            n.rf_row = s.rf_row + 11'h1;
          end
        end
      end
      default:
      begin
        n.st = ST_IDLE;
      end
    endcase

    // Refresh requests are set after the clears above, so only the external reset below can drop a new one.
    if (tick && s.prog_done)
    begin
      n.rf_due = 1'b1;
      if (warm_on || (s.cfg[CFG_RF_AUTO] && p.dis_n))
      begin
        n.rf_pend = 1'b1;
      end
    end
    if (s.prog_done && p.rf_req && (s.cfg[CFG_RF_EXT] || (s.cfg[CFG_RF_REQACK] && s.rf_due)))
    begin
      n.rf_pend = 1'b1;
    end
    if (s.rst_cnt == EXT_RESET_EDGES)
    begin
      n.prog_done = 1'b0;
      n.cfg = CFG_RESET;
      n.warm = 22'h0;
      n.st = ST_IDLE;
      n.rf_pend = 1'b0;
      n.rf_due = 1'b0;
    end

    // Pin values follow the next state so each strobe moves with its state.
    acc = n.st == ST_RAS || n.st == ST_CAS;
    refr = n.st == ST_REF;
    scrub = refr && rtype == RT_SCRUB && n.cnt != 4'h0;
    casgrp = (s.cfg[CFG_BANKS_LSB +: 2] == BANKS_FOUR) ? n.mask : 4'hF;
    row_v = s.cfg[CFG_TRANSP] ? p.row : n.row;
    col_v = s.cfg[CFG_TRANSP] ? p.col : n.col;
    n.ras_n = ~((acc || refr) ? n.mask : 4'h0);
    n.cas_n = ~(((n.st == ST_CAS) ? (~p.cas_en_n & casgrp) : 4'h0) | (scrub ? 4'hF : 4'h0));
    if (refr)
    begin
      n.addr = n.rf_row;
    end
    else if (n.st == ST_CAS && !(s.cfg[CFG_PIPE] && n.cnt >= 4'h2))
    begin
      n.addr = col_v;
    end
    else
    begin
      n.addr = row_v;
    end
    n.we_n = !(n.st == ST_CAS && n.we);
    n.rfip_n = !refr;
    n.hold = p.req_a && !(acc && !n.owner_b);
    waitact = n.hold || (p.req_a && p.ext);
    n.wait_o = s.cfg[CFG_WAIT_DTACK] ? (p.req_a && !waitact) : !waitact;
    n.ack_b = acc && n.owner_b;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.sync1.ml_n <= 1'b1;
      s.sync1.dis_n <= 1'b1;
      s.sync2.ml_n <= 1'b1;
      s.sync2.dis_n <= 1'b1;
      s.cfg <= CFG_RESET;
      s.ras_n <= 4'hF;
      s.cas_n <= 4'hF;
      s.we_n <= 1'b1;
      s.wait_o <= 1'b1;
      s.rfip_n <= 1'b1;
      s.hready <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hready;
  assign hresp = s.h_err;
  assign dram_addr = s.addr;
  assign ras_out_n = s.ras_n;
  assign cas_out_n = s.cas_n;
  assign we_out_n = s.we_n;
  assign wait_out = s.wait_o;
  assign port_b_owner = s.owner_b;
  assign port_b_early_ack = s.ack_b;
  assign refresh_active_n = s.rfip_n;
  assign refresh_due = s.rf_due;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence refresh_start;
    s.st == ST_IDLE ##1 s.st == ST_REF;
  endsequence

  a_refresh_ras_low: assert property (refresh_start |-> (s.ras_n != 4'hF)[*3])
    else $error("refresh RAS pulse shorter than its minimum");

  for (genvar g = 0; g < 4; g++) begin : g_pre_chk
    a_precharge_bank: assert property (s.pre[g] != 3'h0 |-> s.ras_n[g])
      else $error("RAS asserted on a bank still in precharge");
  end

  a_wait_release: assert property (s.st == ST_RAS && !s.owner_b |-> !s.hold)
    else $error("wait still held after RAS started for port A");

  a_wait_blocked: assert property (s.st == ST_REF && $past(s.sync2.req_a) |-> s.hold ##0 !s.wait_o)
    else $error("port A not held off during refresh");

  a_wait_form: assert property (!$past(s.sync2.req_a) |-> s.wait_o == !$past(s.cfg[CFG_WAIT_DTACK]))
    else $error("idle wait output level does not match the chosen form");

  a_warm_cas_off: assert property (s.warm != 22'h0 |-> s.cas_n == 4'hF)
    else $error("CAS asserted during warm-up");

  a_warm_once: assert property (s.prog_done && !s.sync2.ml_n && s.sync2.dis_n |=> s.warm <= $past(s.warm))
    else $error("reprogramming restarted the warm-up");

  a_column_step: assert property (s.st == ST_CAS && s.sync2.step && !s.cfg[CFG_TRANSP]
                                  |=> s.col == 11'($past(s.col) + 11'h1))
    else $error("column step did not advance the column address");

  a_auto_refresh: assert property (s.rf_tmr == 10'(REFRESH_CYC - 1) && s.prog_done
                                   && s.cfg[CFG_RF_AUTO] && s.sync2.dis_n
                                   && s.rst_cnt != EXT_RESET_EDGES |=> s.rf_pend)
    else $error("timer expiry did not raise a refresh request");

  a_cas_enable: assert property (s.st == ST_CAS |-> (~s.cas_n & $past(s.sync2.cas_en_n)) == 4'h0)
    else $error("CAS asserted on a lane whose enable was high");

  a_owner_ack: assert property (s.ack_b |-> s.owner_b ##1 (s.st != ST_IDLE || !s.ack_b))
    else $error("port B acknowledge without port B ownership");

endmodule

`default_nettype wire

/* File: design/darc_pkg.sv */
// Purpose: Shared constants and carriers for the DRAM access and refresh controller.
// Assumes: A 40 MHz system clock; all times below are turned into whole clock cycles.
// Notes: Configuration bits arrive on the column address pins or over AHB-Lite.
package darc_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RAS_MIN_NS = 75;
  localparam int PRECHARGE_NS = 50;
  localparam int REFRESH_NS = 15000;
  localparam int WARMUP_MS = 60;
  localparam int RAS_MIN_CYC = (RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_PERIOD_NS;
  localparam int WARMUP_CYC = WARMUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [4:0] EXT_RESET_EDGES = 5'h10;

  localparam int CFG_W = 11;
  localparam int CFG_WAIT_DTACK = 0;
  localparam int CFG_MODE1 = 1;
  localparam int CFG_RF_AUTO = 2;
  localparam int CFG_RF_EXT = 3;
  localparam int CFG_RF_REQACK = 4;
  localparam int CFG_RTYPE_LSB = 5;
  localparam int CFG_BANKS_LSB = 7;
  localparam int CFG_TRANSP = 9;
  localparam int CFG_PIPE = 10;
  localparam logic [CFG_W-1:0] CFG_RESET = 11'h004;

  localparam logic [1:0] BANKS_ONE = 2'h0;
  localparam logic [1:0] BANKS_TWO = 2'h1;
  localparam logic [1:0] BANKS_FOUR = 2'h2;
  localparam logic [1:0] RT_CONV = 2'h0;
  localparam logic [1:0] RT_SPREAD = 2'h1;
  localparam logic [1:0] RT_SCRUB = 2'h2;

  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARM = 3'h1,
    ST_RAS = 3'h2,
    ST_CAS = 3'h3,
    ST_REF = 3'h4
  } darc_fsm_t;

  typedef struct packed {
    logic [10:0] row;
    logic [10:0] col;
    logic [1:0] bank;
    logic [3:0] cas_en_n;
    logic step;
    logic req_a;
    logic req_b;
    logic wr;
    logic ext;
    logic ml_n;
    logic dis_n;
    logic rf_req;
  } darc_pins_t;

  typedef struct packed {
    logic [4:0] rsv_hi;
    logic [10:0] rf_row;
    logic [8:0] rsv_lo;
    logic [2:0] fsm;
    logic owner_b;
    logic rf_pend;
    logic warm;
    logic prog_done;
  } darc_status_t;

  typedef struct packed {
    darc_pins_t sync1;
    darc_pins_t sync2;
    logic [CFG_W-1:0] cfg;
    logic prog_done;
    logic [21:0] warm;
    logic [4:0] rst_cnt;
    logic [9:0] rf_tmr;
    logic rf_pend;
    logic [1:0] rf_bank;
    logic [10:0] rf_row;
    darc_fsm_t st;
    logic [3:0] cnt;
    logic [3:0][2:0] pre;
    logic [10:0] row;
    logic [10:0] col;
    logic [3:0] mask;
    logic we;
    logic owner_b;
    logic hold;
    logic [10:0] addr;
    logic [3:0] ras_n;
    logic [3:0] cas_n;
    logic we_n;
    logic wait_o;
    logic ack_b;
    logic rfip_n;
    logic rf_due;
    logic h_wr;
    logic [7:0] h_addr;
    logic [31:0] hrdata;
    logic hready;
    logic h_err;
  } darc_state_t;
endpackage

/* File: tb/darc_ctrl_tb.sv */
// Purpose: Self-checking bench for the DRAM access and refresh controller.
// Assumes: AHB-Lite, column step, wait extend and refresh request are driven here; the other pins come from the host model.
// Notes: Warm-up is shortened to 50 cycles; expected results wait in queues.
`timescale 1ns/1ps
`default_nettype none

module darc_ctrl_tb;
  import darc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic [10:0] row_in, col_in, dram_addr;
  logic [1:0] bank_in;
  logic [3:0] cas_en_n, ras_out_n, cas_out_n;
  logic req_a, req_b, wr_in, ml_n, dis_n, we_out_n, wait_out, owner_b, ack_b, rfa_n, rf_due;
  logic step = 1'b0;
  logic extend = 1'b0;
  logic rf_req = 1'b0;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic rd_pend = 1'b0;
  logic [63:0] rd_q[$];
  logic [28:0] acc_q[$];
  logic wexp;
  logic [3:0] ras_prev = 4'hF;
  logic [3:0] cas_prev = 4'hF;
  logic [7:0] seed = 8'h58;
  logic [10:0] row, col;

  always #12.5 hclk = ~hclk;

  darc_ctrl #(.WARMUP_CYCLES(50)) darc_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .row_addr_in(row_in), .col_addr_in(col_in),
    .bank_select_in(bank_in), .cas_enable_in_n(cas_en_n), .column_step_in(step),
    .port_a_request(req_a), .port_b_request(req_b), .write_in(wr_in),
    .wait_extend_in(extend), .program_load_n(ml_n), .refresh_disable_in_n(dis_n),
    .refresh_request_in(rf_req), .dram_addr(dram_addr), .ras_out_n(ras_out_n),
    .cas_out_n(cas_out_n), .we_out_n(we_out_n), .wait_out(wait_out),
    .port_b_owner(owner_b), .port_b_early_ack(ack_b), .refresh_active_n(rfa_n),
    .refresh_due(rf_due));

  darc_host_model darc_host_model_inst (
    .hclk(hclk), .ras_out_n(ras_out_n), .cas_out_n(cas_out_n), .refresh_active_n(rfa_n),
    .row_addr_in(row_in), .col_addr_in(col_in), .bank_select_in(bank_in),
    .cas_enable_in_n(cas_en_n), .port_a_request(req_a), .port_b_request(req_b),
    .write_in(wr_in), .program_load_n(ml_n), .refresh_disable_in_n(dis_n));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // For reads d is the expected data and m the mask of the bits that are compared.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    if (!w)
    begin
      rd_q.push_back({m, d});
      rd_pend <= 1'b1;
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_pend <= 1'b0;
  endtask

  always @(posedge hclk)
  begin
    logic [63:0] r;
    logic [28:0] e;
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      report_and_stop();
    end
    if (rd_pend === 1'b1 && hreadyout === 1'b1)
    begin
      r = rd_q.pop_front();
      chk(hrdata & r[63:32], r[31:0]);
      chk(32'(hresp), 32'h0);
    end
    if (rfa_n === 1'b1 && acc_q.size() > 0)
    begin
      e = acc_q[0];
      if (ras_out_n !== 4'hF && ras_prev === 4'hF)
        chk(32'({owner_b, ack_b, ras_out_n, dram_addr}), 32'({e[27], e[27], ~e[26:23], e[22:12]}));
      if (cas_out_n !== 4'hF && cas_prev === 4'hF)
      begin
        chk(32'({dram_addr, we_out_n, wait_out}),
            32'({e[11:1], ~e[0], e[28]}));
        void'(acc_q.pop_front());
      end
    end
    ras_prev = ras_out_n;
    cas_prev = cas_out_n;
  end

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, REG_CONFIG, 32'(CFG_RESET), 32'hFFFFFFFF);
    ahb(1'b0, 8'h08, 32'h0, 32'hFFFFFFFF);
    ahb(1'b0, REG_STATUS, 32'h0, 32'h3);
    darc_host_model_inst.load(11'h106);
    ahb(1'b0, REG_CONFIG, 32'h106, 32'hFFFFFFFF);
    ahb(1'b0, REG_STATUS, 32'h3, 32'h3);
    repeat (80) @(posedge hclk);
    ahb(1'b0, REG_STATUS, 32'h1, 32'h3);
    ahb(1'b1, REG_CONFIG, 32'h104, 32'h0);
    ahb(1'b0, REG_STATUS, 32'h1, 32'h3);
    for (int p = 0; p < 3; p++)
    begin
      if (p == 1)
        ahb(1'b1, REG_CONFIG, 32'h106, 32'h0);
      if (p == 2)
        ahb(1'b1, REG_CONFIG, 32'h307, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
        seed = lfsr(seed);
        row = {seed[2:0], seed};
        col = {seed, seed[7:5]};
        // Latched passes step the column; the last pass shows acknowledge and extends it.
        step <= seed[3] && p != 2;
        extend <= seed[2] && p == 2;
        wexp = p != 2 || (!seed[0] && !seed[2]);
        acc_q.push_back({wexp, seed[0], 4'h1 << i, row, col, seed[1]});
        darc_host_model_inst.access(2'(i), row, col, seed[1], seed[0]);
      end
    end
    step <= 1'b0;
    extend <= 1'b0;
    wait (rfa_n === 1'b0);
    n = 0;
    while (rfa_n === 1'b0)
    begin
      @(posedge hclk);
      n++;
    end
    chk(32'(n >= RAS_MIN_CYC), 32'h1);
    darc_host_model_inst.soft_reset();
    ahb(1'b0, REG_CONFIG, 32'(CFG_RESET), 32'hFFFFFFFF);
    ahb(1'b0, REG_STATUS, 32'h0, 32'h3);
    report_and_stop();
  end
endmodule

`default_nettype wire

/* File: tb/darc_host_model.sv */
// Purpose: Host side model that drives the pin requests and pin programming of the controller.
// Assumes: Signals change by non-blocking assignment just after a rising edge of hclk.
// Notes: Address pins show the inverse of the last value whenever no access or pin load is under way.
`timescale 1ns/1ps
`default_nettype none

module darc_host_model
  import darc_pkg::*;
(
  input wire logic hclk,
  input wire logic [3:0] ras_out_n,
  input wire logic [3:0] cas_out_n,
  input wire logic refresh_active_n,
  output logic [10:0] row_addr_in,
  output logic [10:0] col_addr_in,
  output logic [1:0] bank_select_in,
  output logic [3:0] cas_enable_in_n,
  output logic port_a_request,
  output logic port_b_request,
  output logic write_in,
  output logic program_load_n,
  output logic refresh_disable_in_n
);
  initial
  begin
    row_addr_in = 11'h7FF;
    col_addr_in = 11'h7FF;
    bank_select_in = 2'h3;
    cas_enable_in_n = 4'hF;
    port_a_request = 1'b0;
    port_b_request = 1'b0;
    write_in = 1'b0;
    program_load_n = 1'b1;
    refresh_disable_in_n = 1'b1;
  end

  // The request is held until two cycles after CAS shows, so the access is never cut short.
  task automatic access(input logic [1:0] b, input logic [10:0] r, input logic [10:0] c,
                        input logic w, input logic pb);
    @(posedge hclk);
    row_addr_in <= r;
    col_addr_in <= c;
    bank_select_in <= b;
    write_in <= w;
    cas_enable_in_n <= 4'h0;
    port_a_request <= !pb;
    port_b_request <= pb;
    do @(posedge hclk); while (!(cas_out_n !== 4'hF && refresh_active_n === 1'b1));
    repeat (2) @(posedge hclk);
    port_a_request <= 1'b0;
    port_b_request <= 1'b0;
    row_addr_in <= ~r;
    col_addr_in <= ~c;
    cas_enable_in_n <= 4'hF;
    do @(posedge hclk); while (ras_out_n !== 4'hF);
    repeat (4) @(posedge hclk);
  endtask

  task automatic load(input logic [10:0] cfg);
    @(posedge hclk);
    col_addr_in <= cfg;
    program_load_n <= 1'b0;
    repeat (4) @(posedge hclk);
    program_load_n <= 1'b1;
    col_addr_in <= ~cfg;
    repeat (4) @(posedge hclk);
  endtask

  // Mode load is released before refresh disable so that nothing is loaded.
  task automatic soft_reset();
    @(posedge hclk);
    program_load_n <= 1'b0;
    refresh_disable_in_n <= 1'b0;
    repeat (20) @(posedge hclk);
    program_load_n <= 1'b1;
    repeat (3) @(posedge hclk);
    refresh_disable_in_n <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask
endmodule

`default_nettype wire
